// ===== hdl/eip_consts.vh
`ifndef EIP_CONSTS_VH
`define EIP_CONSTS_VH
// register byte addresses
`define EIP_ADDR_SC 12'h000
`define EIP_ADDR_IRQ_STAT 12'h004
`define EIP_ADDR_IRQ_EN 12'h008
`define EIP_ADDR_IRQ_CLR 12'h00c
`define EIP_ADDR_VEC 12'h010
// status/control field positions
`define EIP_BIT_LEVEL 0
`define EIP_BIT_MASK 1
`define EIP_BIT_ACK 2
`define EIP_BIT_PEND 3
// vector locations
`define EIP_VEC_LO 16'hfffa
`define EIP_VEC_HI 16'hfffb
// event bits in the interrupt status register
`define EIP_EV_LATCH 0
`define EIP_EV_ACK 1
`define EIP_EV_W 2
`define EIP_SC_RESET 8'h00
`endif

// ===== hdl/eip_sync.v
`timescale 1ns/1ps
// two-stage synchroniser, resets to the idle (high) level of the pin
module eip_sync (
  input wire hclk,
  input wire hresetn,
  input wire d,
  output reg q
);
  reg meta_r;
  // the first stage feeds only the second
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ===== hdl/eip_irq_regs.v
`timescale 1ns/1ps
`include "eip_consts.vh"
// sticky event status, enable and write-one-to-clear, with one level output
module eip_irq_regs #(
  parameter W = `EIP_EV_W
) (
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] ev,
  input wire en_we,
  input wire clr_we,
  input wire [W-1:0] wdata,
  output reg [W-1:0] stat_r,
  output reg [W-1:0] en_r,
  output reg irq_r
);
  wire [W-1:0] stat_nxt;
  // a new event wins over a clear in the same cycle
  assign stat_nxt = (stat_r & ~(clr_we ? wdata : {W{1'b0}})) | ev;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= {W{1'b0}};
      en_r <= {W{1'b0}};
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (en_we) begin
        en_r <= wdata;
      end
      irq_r <= |(stat_nxt & (en_we ? wdata : en_r));
    end
  end
endmodule

// ===== hdl/eip_top.v
`timescale 1ns/1ps
`include "eip_consts.vh"
// Function
// - falling pin edge (low pin in level mode) sets the latch; vector fetch, acknowledge or reset clears it
// - level select set: pin responds to falling edges and low levels
// - level mode: clear needs acknowledge and pin high, either order
// - level mode: request stays pending while the pin is low
// - writing one to the acknowledge strobe acts like a vector fetch
// - a falling edge after an acknowledge latches a new request
// - unmasked latched request makes the cpu fetch vectors fffa and fffb
// - reset clears latch and level select even with pin low
// - level select clear: edge only, acknowledge clears the latch at once
// - pending flag reads latch state, independent of the mask
// - in break with clear enable low, acknowledge writes do nothing
// - in break with clear enable high, acknowledge clears and stays cleared
// - acknowledge strobe is write-only, reads zero, reset clears it
// - mask bit read/write, one blocks requests, reset clears it
// - level select read/write, reset clears it, one adds low levels
// - pending bit 3, acknowledge bit 2, mask bit 1, level bit 0
module eip_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire pin_n,
  input wire vector_fetch,
  input wire break_state,
  input wire break_clear_enable,
  output reg cpu_req,
  output reg [15:0] vector_addr,
  output reg irq
);
  // bus address phase capture
  reg wr_pend_r;
  reg [11:0] addr_r;
  reg rd_pend_r;
  // control state
  reg pin_request_mask_r;
  reg level_sel_r;
  reg pin_request_latch_r;
  reg ack_seen_r;
  reg pin_prev_r;
  reg vec_cnt_r;
  reg [1:0] warm_r;
  wire pin_s;
  wire [1:0] ev_stat;
  wire [1:0] ev_en;
  wire irq_w;
  reg [31:0] rdata_nxt;
  wire addr_ok;
  wire sw_ack;
  wire any_ack;
  wire fall;
  wire latch_nxt;
  wire ack_done;
  wire set_ev;

  // decode of a valid transfer
  function is_xfer;
    input s;
    input [1:0] t;
    input r;
    begin
      is_xfer = s & t[1] & r;
    end
  endfunction

  // pin synchroniser
  eip_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(pin_n),
    .q(pin_s)
  );

  assign addr_ok = 1'b1;
  // edges count only once the synchroniser holds real pin samples, so a pin
  // held low through reset does not look like a fresh falling edge
  assign fall = pin_prev_r & ~pin_s & (warm_r == 2'h3);
  // acknowledge write from software, gated in break state
  assign sw_ack = wr_pend_r && (addr_r == `EIP_ADDR_SC) && hwdata[`EIP_BIT_ACK]
                  && (!break_state || break_clear_enable);
  assign any_ack = sw_ack | vector_fetch;
  // level mode: acknowledge remembered until the pin returns high
  assign ack_done = any_ack | ack_seen_r;
  assign set_ev = level_sel_r ? ~pin_s : fall;
  assign latch_nxt = set_ev ? 1'b1 :
                     (level_sel_r ? (pin_request_latch_r & ~(ack_done & pin_s))
                                  : (pin_request_latch_r & ~any_ack));

  // address phase capture and pin history
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 12'h000;
      pin_prev_r <= 1'b1;
      warm_r <= 2'h0;
    end else begin
      if (warm_r != 2'h3) begin
        warm_r <= warm_r + 2'h1;
      end
      wr_pend_r <= is_xfer(hsel, htrans, hready) & hwrite;
      rd_pend_r <= is_xfer(hsel, htrans, hready) & ~hwrite;
      addr_r <= haddr;
      pin_prev_r <= pin_s;
    end
  end

  // latch, mask, level select and acknowledge memory
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_request_latch_r <= 1'b0;
      level_sel_r <= 1'b0;
      pin_request_mask_r <= 1'b0;
      ack_seen_r <= 1'b0;
    end else begin
      pin_request_latch_r <= latch_nxt;
      if (!latch_nxt) begin
        ack_seen_r <= 1'b0;
      end else if (any_ack && level_sel_r) begin
        ack_seen_r <= 1'b1;
      end
      if (wr_pend_r && addr_r == `EIP_ADDR_SC) begin
        pin_request_mask_r <= hwdata[`EIP_BIT_MASK];
        level_sel_r <= hwdata[`EIP_BIT_LEVEL];
      end
    end
  end

  // cpu request and vector address sequence
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_req <= 1'b0;
      vector_addr <= `EIP_VEC_LO;
      vec_cnt_r <= 1'b0;
    end else begin
      cpu_req <= latch_nxt & ~pin_request_mask_r;
      if (vector_fetch) begin
        vec_cnt_r <= ~vec_cnt_r;
        vector_addr <= vec_cnt_r ? `EIP_VEC_LO : `EIP_VEC_HI;
      end
    end
  end

  // interrupt status: latch set and acknowledge events
  eip_irq_regs #(
    .W(`EIP_EV_W)
  ) u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .ev({any_ack & pin_request_latch_r, ~pin_request_latch_r & latch_nxt}),
    .en_we(wr_pend_r && addr_r == `EIP_ADDR_IRQ_EN),
    .clr_we(wr_pend_r && addr_r == `EIP_ADDR_IRQ_CLR),
    .wdata(hwdata[`EIP_EV_W-1:0]),
    .stat_r(ev_stat),
    .en_r(ev_en),
    .irq_r(irq_w)
  );

  // read mux
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (haddr)
      `EIP_ADDR_SC: begin
        rdata_nxt[`EIP_BIT_PEND] = pin_request_latch_r;
        rdata_nxt[`EIP_BIT_MASK] = pin_request_mask_r;
        rdata_nxt[`EIP_BIT_LEVEL] = level_sel_r;
      end
      `EIP_ADDR_IRQ_STAT: rdata_nxt[`EIP_EV_W-1:0] = ev_stat;
      `EIP_ADDR_IRQ_EN: rdata_nxt[`EIP_EV_W-1:0] = ev_en;
      `EIP_ADDR_VEC: rdata_nxt[15:0] = vector_addr;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // bus answers: zero wait states, always okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
    end else begin
      hreadyout <= addr_ok;
      hresp <= 1'b0;
      irq <= irq_w;
      if (is_xfer(hsel, htrans, hready) && !hwrite) begin
        hrdata <= rdata_nxt;
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end
endmodule

// ===== tb/eip_pin_model.sv
`timescale 1ns/1ps
// external device on the request pin, idle high
module eip_pin_model (
  input wire hclk,
  output logic pin_n = 1'b1
);
  // move the pin just after an edge, then hold it n cycles
  task drive(input logic l, input int n);
    @(posedge hclk);
    pin_n <= l;
    repeat (n) @(posedge hclk);
  endtask
endmodule

// ===== tb/eip_chk_assertions.sv
`timescale 1ns/1ps
// port properties of the pin interrupt unit
module eip_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire pin_n,
  input wire vector_fetch,
  input wire cpu_req,
  input wire [15:0] vector_addr,
  input wire irq
);
  wire go = hsel && htrans[1];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // pin low, bus idle and no fetch for three cycles
  sequence s_calm;
    (!go && !vector_fetch && !pin_n) [*3];
  endsequence
  a_ready_high: assert property (hreadyout) else $error("stall");
  a_resp_okay: assert property (!hresp) else $error("resp");
  a_vec_step: assert property (vector_fetch |=> vector_addr == ($past(vector_addr) ^ 16'h1))
    else $error("vec step");
  a_vec_hold: assert property (!vector_fetch |=> $stable(vector_addr)) else $error("vec");
  a_vec_pair: assert property (vector_addr[15:1] == 15'h7ffd) else $error("vec pair");
  a_rdata_idle: assert property (!go |=> hrdata == 32'h0) else $error("rdata");
  a_req_hold: assert property (s_calm ##0 cpu_req |=> cpu_req) else $error("req");
  a_irq_hold: assert property (s_calm ##0 irq |=> irq) else $error("irq");
endmodule
bind eip_top eip_chk i_chk (.*);

// ===== tb/external_interrupt_pin_unit_tb_top.sv
`timescale 1ns/1ps
`include "eip_consts.vh"
module external_interrupt_pin_unit_tb_top;
  localparam logic [11:0] SC = `EIP_ADDR_SC;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready = 1;
  logic vector_fetch = 0, break_state = 0, break_clear_enable = 0;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 0, rd;
  wire [31:0] hrdata;
  wire [15:0] vector_addr;
  wire hreadyout, hresp, cpu_req, irq, pin_n;
  int num_errors = 0, checks = 0;
  eip_pin_model i_pin (.hclk(hclk), .pin_n(pin_n));
  eip_top i_dut (.*);
  // bus clock
  always #12.5 hclk = ~hclk;
  task report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, got);
    end
  endtask
  // one bus phase, ended by ready at a rising edge
  task phase(inout int n);
    do begin
      @(negedge hclk);
      rd = hrdata;
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    @(posedge hclk);
  endtask
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    phase(n);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    phase(n);
    if (n >= 40) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(nm, rd, e);
  endtask
  // settle, then check request and interrupt levels
  task lv(input logic q, i);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("req", cpu_req, q);
    chk("irq", irq, i);
    @(posedge hclk);
  endtask
  // edge mode, acknowledge, mask, unmapped place
  task t_edge();
    rc("sc", SC, 32'h0);
    rc("gap", 12'h020, 32'h0);
    i_pin.drive(0, 5);
    rc("pend", SC, 32'h8);
    lv(1, 0);
    bus(1, SC, 32'h4);
    rc("ack", SC, 32'h0);
    i_pin.drive(1, 3);
    i_pin.drive(0, 5);
    rc("again", SC, 32'h8);
    bus(1, SC, 32'h6);
    i_pin.drive(1, 3);
    i_pin.drive(0, 5);
    rc("mask", SC, 32'ha);
    lv(0, 0);
    bus(1, SC, 32'h4);
  endtask
  // level mode needs acknowledge and pin high
  task t_level();
    bus(1, SC, 32'h1);
    i_pin.drive(0, 5);
    rc("lvl", SC, 32'h9);
    bus(1, SC, 32'h5);
    rc("hold", SC, 32'h9);
    i_pin.drive(1, 5);
    rc("rel", SC, 32'h1);
    i_pin.drive(0, 5);
    vector_fetch <= 1'h1;
    @(posedge hclk);
    vector_fetch <= 1'h0;
    lv(1, 0);
    chk("vec", vector_addr, 32'hfffb);
    rc("vrd", `EIP_ADDR_VEC, 32'hfffb);
    i_pin.drive(1, 5);
    rc("vrel", SC, 32'h1);
    i_pin.drive(0, 5);
    i_pin.drive(1, 5);
    rc("ord", SC, 32'h9);
    bus(1, SC, 32'h5);
    rc("ord2", SC, 32'h1);
  endtask
  // break state, clear enable low then high
  task t_brk();
    bus(1, SC, 32'h0);
    break_state <= 1'h1;
    i_pin.drive(0, 5);
    bus(1, SC, 32'h4);
    rc("brk", SC, 32'h8);
    break_clear_enable <= 1'h1;
    bus(1, SC, 32'h4);
    break_state <= 1'h0;
    rc("brkc", SC, 32'h0);
    i_pin.drive(1, 3);
  endtask
  // sticky events, enable and clear
  task t_irq();
    bus(1, `EIP_ADDR_IRQ_CLR, 32'h3);
    bus(1, `EIP_ADDR_IRQ_EN, 32'h1);
    rc("st0", `EIP_ADDR_IRQ_STAT, 32'h0);
    i_pin.drive(0, 5);
    rc("st1", `EIP_ADDR_IRQ_STAT, 32'h1);
    lv(1, 1);
    bus(1, `EIP_ADDR_IRQ_EN, 32'h2);
    lv(1, 0);
    bus(1, SC, 32'h4);
    lv(0, 1);
    bus(1, `EIP_ADDR_IRQ_CLR, 32'h3);
    lv(0, 0);
  endtask
  // reset with the pin held low
  task t_rst();
    bus(1, SC, 32'h3);
    hresetn <= 1'h0;
    lv(0, 0);
    hresetn <= 1'h1;
    repeat (6) @(posedge hclk);
    bus(0, SC, 0);
    chk("rst", rd & 32'hf, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    t_edge();
    t_level();
    t_brk();
    t_irq();
    t_rst();
    report_and_stop();
  end
endmodule
